// ### hw/dnsc_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "dnsc_map.svh"

module dnsc_bank (
	input wire logic mclk_i,
	input wire logic srst_i,
	// parameter access port
	input wire logic acc_wr_i,
	input wire logic acc_rd_i,
	input wire logic [1:0] acc_sel_i,
	input wire dnsc_pkg::dnsc_word_t acc_wdata_i,
	input wire dnsc_pkg::dnsc_source_e acc_src_i,
	output dnsc_pkg::dnsc_word_t acc_rdata_o,
	output logic acc_rvalid_o,
	output logic acc_werr_o,
	// drive core side
	input wire dnsc_pkg::dnsc_core_status_s core_status_i,
	input wire logic signed [31:0] core_speed_i,
	input wire logic serial_ctrl_i,
	output dnsc_pkg::dnsc_command_s core_cmd_o,
	output logic core_cmd_valid_o,
	output logic fault_reset_o
);
	import dnsc_pkg::*;

	dnsc_word_t status_word;
	dnsc_word_t speed_word;
	dnsc_word_t serial_command_word;
	dnsc_freset_e fr_state;
	logic cmd_write;

	function automatic dnsc_word_t read_mux(input logic [1:0] sel, input dnsc_word_t st,
		input dnsc_word_t sp, input dnsc_word_t cm);
		dnsc_word_t r;
		r = `DNSC_RESET_WORD;
		case (sel)
			`DNSC_SEL_STATUS: r = st;
			`DNSC_SEL_SPEED: r = sp;
			`DNSC_SEL_COMMAND: r = cm;
			default: r = `DNSC_RESET_WORD;
		endcase
		return r;
	endfunction

	dnsc_status_pack u_status (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.core_i(core_status_i),
		.status_o(status_word)
	);

	dnsc_speed_scale u_speed (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.speed_i(core_speed_i),
		.speed_o(speed_word)
	);

	// only the serial source may change the command word
	assign cmd_write = acc_wr_i && (acc_sel_i == `DNSC_SEL_COMMAND)
		&& (acc_src_i == DNSC_SRC_SERIAL);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			serial_command_word <= `DNSC_RESET_WORD;
		end else if (cmd_write) begin
			serial_command_word <= acc_wdata_i & `DNSC_CMD_USED_MASK;
		end
	end

	// writes to read-only words, or from a non-serial source, are flagged
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			acc_werr_o <= 1'b0;
		end else begin
			acc_werr_o <= acc_wr_i && !cmd_write;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			acc_rdata_o <= `DNSC_RESET_WORD;
			acc_rvalid_o <= 1'b0;
		end else begin
			acc_rvalid_o <= acc_rd_i;
			if (acc_rd_i) begin
				acc_rdata_o <= read_mux(acc_sel_i, status_word, speed_word,
					serial_command_word);
			end
		end
	end

	// commands reach the core only while serial holds command authority;
	// the word itself is still stored so a later handover takes effect
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			core_cmd_o <= '0;
			core_cmd_valid_o <= 1'b0;
		end else begin
			core_cmd_valid_o <= serial_ctrl_i;
			if (serial_ctrl_i) begin
				core_cmd_o.run <= serial_command_word[`DNSC_CMD_RUN];
				core_cmd_o.general_enable <= serial_command_word[`DNSC_CMD_GEN_EN];
				core_cmd_o.direction <= serial_command_word[`DNSC_CMD_DIR];
				core_cmd_o.inching_function <= serial_command_word[`DNSC_CMD_JOG];
				core_cmd_o.local_remote_select <= serial_command_word[`DNSC_CMD_REMOTE];
				core_cmd_o.alternate_ramp <= serial_command_word[`DNSC_CMD_RAMP2];
				core_cmd_o.quick_stop <= serial_command_word[`DNSC_CMD_QSTOP];
			end else begin
				core_cmd_o <= '0;
			end
		end
	end

	// fault reset is a one-cycle pulse per write of bit 7 accepted in DNSC_FR_IDLE with a fault while serial holds command authority
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fr_state <= DNSC_FR_IDLE;
			fault_reset_o <= 1'b0;
		end else begin
			fault_reset_o <= 1'b0;
			case (fr_state)
				DNSC_FR_IDLE: begin
					if (cmd_write && acc_wdata_i[`DNSC_CMD_FRESET] && serial_ctrl_i
						&& core_status_i.fault_present) begin
						fr_state <= DNSC_FR_PULSE;
					end
				end
				DNSC_FR_PULSE: begin
					fault_reset_o <= 1'b1;
					fr_state <= DNSC_FR_WAIT;
				end
				DNSC_FR_WAIT: begin
					fr_state <= DNSC_FR_IDLE;
				end
				default: fr_state <= DNSC_FR_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### inc/dnsc_map.svh
`ifndef DNSC_MAP_SVH
`define DNSC_MAP_SVH

// word selectors on the parameter access port
`define DNSC_SEL_STATUS 2'h0
`define DNSC_SEL_SPEED 2'h1
`define DNSC_SEL_COMMAND 2'h2

// status word bit positions
`define DNSC_ST_STO 0
`define DNSC_ST_RUN 1
`define DNSC_ST_QSTOP 4
`define DNSC_ST_RAMP2 5
`define DNSC_ST_CONFIG 6
`define DNSC_ST_ALARM 7
`define DNSC_ST_MOVING 8
`define DNSC_ST_GEN_EN 9
`define DNSC_ST_FWD 10
`define DNSC_ST_JOG 11
`define DNSC_ST_REMOTE 12
`define DNSC_ST_UNDERV 13
`define DNSC_ST_AUTO 14
`define DNSC_ST_FAULT 15

// command word bit positions
`define DNSC_CMD_RUN 0
`define DNSC_CMD_GEN_EN 1
`define DNSC_CMD_DIR 2
`define DNSC_CMD_JOG 3
`define DNSC_CMD_REMOTE 4
`define DNSC_CMD_RAMP2 5
`define DNSC_CMD_QSTOP 6
`define DNSC_CMD_FRESET 7
`define DNSC_CMD_USED_MASK 16'h00FF

// speed scaling: 8192 counts equal rated frequency
`define DNSC_SPEED_RATED 16'h2000
`define DNSC_SPEED_MAX 32'sh00007FFF
`define DNSC_SPEED_MIN -32'sh00008000
`define DNSC_SPEED_SAT_HI 16'h7FFF
`define DNSC_SPEED_SAT_LO 16'h8000

`define DNSC_RESET_WORD 16'h0000

`endif

// ### inc/dnsc_pkg.sv
package dnsc_pkg;
	typedef logic [15:0] dnsc_word_t;

	// drive core state reported in the status word
	typedef struct packed {
		logic safe_torque_off_flag;
		logic run_active;
		logic quick_stop_active;
		logic alternate_ramp;
		logic config_mode;
		logic alarm_present;
		logic motor_moving;
		logic general_enable_ready;
		logic forward;
		logic inching_function;
		logic remote;
		logic undervoltage;
		logic process_regulator_auto;
		logic fault_present;
	} dnsc_core_status_s;

	// decoded commands handed to the drive core
	typedef struct packed {
		logic run;
		logic general_enable;
		logic direction;
		logic inching_function;
		logic local_remote_select;
		logic alternate_ramp;
		logic quick_stop;
	} dnsc_command_s;

	typedef enum logic [1:0] {
		DNSC_SRC_SERIAL,
		DNSC_SRC_KEYPAD,
		DNSC_SRC_OTHER
	} dnsc_source_e;

	typedef enum {
		DNSC_FR_IDLE,
		DNSC_FR_PULSE,
		DNSC_FR_WAIT
	} dnsc_freset_e;
endpackage

// ### hw/dnsc_speed_scale.sv
`timescale 1ns/1ps
`default_nettype none
`include "dnsc_map.svh"

// clamps a signed wide speed to the 16-bit network word
module dnsc_speed_scale (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic signed [31:0] speed_i,
	output logic [15:0] speed_o
);
	import dnsc_pkg::*;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			speed_o <= `DNSC_RESET_WORD;
		end else if (speed_i > `DNSC_SPEED_MAX) begin
			speed_o <= `DNSC_SPEED_SAT_HI;
		end else if (speed_i < `DNSC_SPEED_MIN) begin
			speed_o <= `DNSC_SPEED_SAT_LO;
		end else begin
			speed_o <= speed_i[15:0];
		end
	end
endmodule
`default_nettype wire

// ### hw/dnsc_status_pack.sv
`timescale 1ns/1ps
`default_nettype none
`include "dnsc_map.svh"

module dnsc_status_pack (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire dnsc_pkg::dnsc_core_status_s core_i,
	output logic [15:0] status_o
);
	import dnsc_pkg::*;

	logic [15:0] next_status;

	always_comb begin
		next_status = `DNSC_RESET_WORD;
		next_status[`DNSC_ST_STO] = core_i.safe_torque_off_flag;
		next_status[`DNSC_ST_RUN] = core_i.run_active;
		next_status[`DNSC_ST_QSTOP] = core_i.quick_stop_active;
		next_status[`DNSC_ST_RAMP2] = core_i.alternate_ramp;
		next_status[`DNSC_ST_CONFIG] = core_i.config_mode;
		next_status[`DNSC_ST_ALARM] = core_i.alarm_present;
		next_status[`DNSC_ST_MOVING] = core_i.motor_moving;
		next_status[`DNSC_ST_GEN_EN] = core_i.general_enable_ready;
		next_status[`DNSC_ST_FWD] = core_i.forward;
		next_status[`DNSC_ST_JOG] = core_i.inching_function;
		next_status[`DNSC_ST_REMOTE] = core_i.remote;
		next_status[`DNSC_ST_UNDERV] = core_i.undervoltage;
		next_status[`DNSC_ST_AUTO] = core_i.process_regulator_auto;
		next_status[`DNSC_ST_FAULT] = core_i.fault_present;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			status_o <= `DNSC_RESET_WORD;
		end else begin
			status_o <= next_status;
		end
	end
endmodule
`default_nettype wire

// ### bench/dnsc_master.sv
`timescale 1ns/1ps
`default_nettype none
module dnsc_master (
	input wire logic mclk_i,
	output logic wr_o,
	output logic rd_o,
	output logic [1:0] sel_o,
	output dnsc_pkg::dnsc_word_t wdata_o,
	output dnsc_pkg::dnsc_source_e src_o
);
	import dnsc_pkg::*;
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		sel_o = 2'h3;
		wdata_o = 16'hA5A5;
		src_o = DNSC_SRC_SERIAL;
	end
	// one strobe per frame; data is inverted after it so no stale word lingers
	task automatic xfer(input logic w, input logic [1:0] s, input dnsc_word_t d, input dnsc_source_e o);
		@(negedge mclk_i);
		wr_o = w;
		rd_o = !w;
		sel_o = s;
		wdata_o = d;
		src_o = o;
		@(negedge mclk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = ~d;
	endtask
endmodule
`default_nettype wire

// ### bench/dnsc_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dnsc_bank_props (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic acc_wr_i,
	input wire logic acc_rd_i,
	input wire logic [1:0] acc_sel_i,
	input wire dnsc_pkg::dnsc_word_t acc_wdata_i,
	input wire dnsc_pkg::dnsc_source_e acc_src_i,
	input wire dnsc_pkg::dnsc_word_t acc_rdata_o,
	input wire dnsc_pkg::dnsc_core_status_s core_status_i,
	input wire logic serial_ctrl_i,
	input wire dnsc_pkg::dnsc_command_s core_cmd_o,
	input wire logic fault_reset_o
);
	import dnsc_pkg::*;
	logic rs, frq, s_off, s_run, s_flt;
	logic [6:0] wmap;
	assign rs = acc_rd_i && acc_sel_i == 2'h0;
	assign frq = acc_wr_i && acc_wdata_i[7] && acc_sel_i == 2'h2 && acc_src_i == DNSC_SRC_SERIAL;
	assign s_off = core_status_i.safe_torque_off_flag;
	assign s_run = core_status_i.run_active;
	assign s_flt = core_status_i.fault_present;
	// the command struct lists run first, so its bit order is mirrored
	always_comb for (int i = 0; i < 7; i++) wmap[6 - i] = acc_wdata_i[i];
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	AST_SAFE_OFF: assert property (rs && !$past(srst_i) |=> acc_rdata_o[0] == $past(s_off, 2))
		else $error("status bit 0 wrong");
	AST_RUN: assert property (rs && !$past(srst_i) |=> acc_rdata_o[1] == $past(s_run, 2))
		else $error("status bit 1 wrong");
	AST_FAULT: assert property (rs && !$past(srst_i) |=> acc_rdata_o[15] == $past(s_flt, 2))
		else $error("status bit 15 wrong");
	AST_RSVD: assert property (acc_rd_i && acc_sel_i == 2'h2 |=> acc_rdata_o[15:8] == 8'h00)
		else $error("reserved command bits set");
	AST_NOAUTH: assert property (!serial_ctrl_i |=> core_cmd_o == 7'h00)
		else $error("command active without authority");
	AST_CMD: assert property (acc_wr_i && acc_sel_i == 2'h2 && acc_src_i == DNSC_SRC_SERIAL
		##1 serial_ctrl_i && !acc_wr_i |=> core_cmd_o == $past(wmap, 2))
		else $error("command bits misplaced");
	AST_FR_CAUSE: assert property ($rose(fault_reset_o) |-> $past(frq, 2))
		else $error("fault reset without request");
	AST_FR_PULSE: assert property (fault_reset_o |=> !fault_reset_o)
		else $error("fault reset too long");
endmodule
bind dnsc_bank dnsc_bank_props u_dnsc_bank_props (.mclk_i(mclk_i), .srst_i(srst_i),
	.acc_wr_i(acc_wr_i), .acc_rd_i(acc_rd_i), .acc_sel_i(acc_sel_i), .acc_wdata_i(acc_wdata_i),
	.acc_src_i(acc_src_i), .acc_rdata_o(acc_rdata_o), .core_status_i(core_status_i),
	.serial_ctrl_i(serial_ctrl_i), .core_cmd_o(core_cmd_o), .fault_reset_o(fault_reset_o));
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dnsc_pkg::*;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic wr, rd, rv, werr, cv, frs;
	logic sctl = 1'b1;
	logic [1:0] sel;
	logic [13:0] rev;
	dnsc_word_t wd, rdat;
	dnsc_source_e src;
	dnsc_core_status_s cs = '0;
	dnsc_command_s cmd;
	logic signed [31:0] spd = 32'sh0;
	logic signed [31:0] sv[6] = '{32'sh0, 32'sh2000, -32'sh2000, 32'sh7FFF, 32'sh8000, -32'sh8001};
	dnsc_word_t se[6] = '{16'h0000, 16'h2000, 16'hE000, 16'h7FFF, 16'h7FFF, 16'h8000};
	dnsc_word_t exp_q[$];
	int fails = 0;
	int checks_done = 0;
	int seed = 32'hf671629f;
	dnsc_word_t n;
	always #2.5 mclk_i = ~mclk_i;
	dnsc_bank u_dnsc_bank (.mclk_i(mclk_i), .srst_i(srst_i), .acc_wr_i(wr), .acc_rd_i(rd),
		.acc_sel_i(sel), .acc_wdata_i(wd), .acc_src_i(src), .acc_rdata_o(rdat), .acc_rvalid_o(rv),
		.acc_werr_o(werr), .core_status_i(cs), .core_speed_i(spd), .serial_ctrl_i(sctl),
		.core_cmd_o(cmd), .core_cmd_valid_o(cv), .fault_reset_o(frs));
	dnsc_master u_dnsc_master (.mclk_i(mclk_i), .wr_o(wr), .rd_o(rd), .sel_o(sel), .wdata_o(wd),
		.src_o(src));
	task automatic check(input dnsc_word_t seen, input dnsc_word_t exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	always @(posedge mclk_i) begin
		#1;
		if (rv === 1'b1 && exp_q.size() > 0) check(rdat, exp_q.pop_front());
	end
	task automatic rdw(input logic [1:0] s, input dnsc_word_t e);
		exp_q.push_back(e);
		u_dnsc_master.xfer(1'b0, s, 16'h0000, DNSC_SRC_SERIAL);
	endtask
	task automatic wrw(input logic [1:0] s, input dnsc_word_t d, input dnsc_source_e o);
		u_dnsc_master.xfer(1'b1, s, d, o);
		check({15'h0, werr}, {15'h0, s != 2'h2 || o != DNSC_SRC_SERIAL});
	endtask
	task automatic pulses(input dnsc_word_t e);
		n = '0;
		repeat (6) @(negedge mclk_i) n += frs;
		check(16'(n), e);
	endtask
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i) srst_i = 1'b0;
		repeat (12) begin
			@(negedge mclk_i) cs = 14'($random(seed));
			rev = {<<{cs}};
			rdw(2'h0, {rev[13:2], 2'h0, rev[1:0]});
		end
		wrw(2'h0, 16'hFFFF, DNSC_SRC_SERIAL);
		$display("status test done");
		foreach (sv[i]) begin
			@(negedge mclk_i) spd = sv[i];
			rdw(2'h1, se[i]);
		end
		rdw(2'h3, 16'h0000);
		$display("speed test done");
		cs = '0;
		for (int i = 0; i < 7; i++) begin
			wrw(2'h2, 16'hFF00 | (16'h0001 << i), DNSC_SRC_SERIAL);
			rdw(2'h2, 16'h0001 << i);
			check({8'h0, cv, cmd}, 16'h0080 | (16'h0040 >> i));
		end
		wrw(2'h2, 16'h0000, DNSC_SRC_KEYPAD);
		wrw(2'h2, 16'h0000, DNSC_SRC_OTHER);
		rdw(2'h2, 16'h0040);
		sctl = 1'b0;
		repeat (2) @(negedge mclk_i);
		check({8'h0, cv, cmd}, 16'h0000);
		$display("command test done");
		sctl = 1'b1;
		cs.fault_present = 1'b1;
		wrw(2'h2, 16'h0080, DNSC_SRC_SERIAL);
		pulses(16'h0001);
		wrw(2'h2, 16'h0000, DNSC_SRC_SERIAL);
		pulses(16'h0000);
		cs.fault_present = 1'b0;
		wrw(2'h2, 16'h0080, DNSC_SRC_SERIAL);
		pulses(16'h0000);
		cs.fault_present = 1'b1;
		sctl = 1'b0;
		wrw(2'h2, 16'h0080, DNSC_SRC_SERIAL);
		pulses(16'h0000);
		$display("fault reset test done");
		repeat (3) @(negedge mclk_i);
		check(16'(exp_q.size()), 16'h0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
